// ---- common/tras_pkg.sv ----
package tras_pkg;
	localparam int TRAS_TRIBS = 7;
	localparam int TRAS_E2_TRIBS = 4;
	localparam logic [7:0] TRAS_OFS_STATUS2 = 8'h00;
	localparam logic [7:0] TRAS_OFS_MASTER = 8'h04;
	localparam logic [7:0] TRAS_OFS_MASK = 8'h08;
	localparam logic [7:0] TRAS_OFS_LIVE = 8'h0c;
	localparam logic [7:0] TRAS_OFS_CONFIG = 8'h10;
	localparam int TRAS_RAI_LSB = 0;
	localparam int TRAS_IE_BIT = 7;
	localparam int TRAS_SN_LSB = 8;
	localparam int TRAS_SOF_LSB = 12;
	localparam int TRAS_MSR_RAI_BIT = 0;
	localparam int TRAS_LIVE_AIS_LSB = 0;
	localparam int TRAS_LIVE_LOF_LSB = 8;
	localparam int TRAS_LIVE_RAI_LSB = 16;
	localparam logic TRAS_IE_RST = 1'b0;
	localparam logic TRAS_MASK_RST = 1'b0;
	localparam logic [1:0] TRAS_CONFIG_RST = 2'h0;
	localparam logic [12:0] TRAS_T2_WIN_BITS = 13'h1260;
	localparam logic [12:0] TRAS_E2_FRAME_BITS = 13'h0350;
	localparam logic [12:0] TRAS_G747_FRAME_BITS = 13'h0348;
	localparam logic [3:0] TRAS_T2_AIS_MAX_ZEROS = 4'h8;
	localparam logic [3:0] TRAS_FRM_AIS_MAX_ZEROS = 4'h4;
	localparam logic [2:0] TRAS_RAI_FRAMES = 3'h4;
	localparam logic [2:0] TRAS_FAS_BAD_LIMIT = 3'h4;
	localparam int TRAS_F_WINDOW = 5;
	localparam int TRAS_M_WINDOW = 4;
	localparam logic [2:0] TRAS_ERR_LIMIT = 3'h2;
	typedef enum logic [1:0] {
		TRAS_MODE_T2,
		TRAS_MODE_E2,
		TRAS_MODE_G747
	} tras_mode_t;
endpackage

// ---- logic/tras_detector.sv ----
`timescale 1ns/1ns
module tras_detector import tras_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input tras_mode_t mode,
	input wire logic bitValid,
	input wire logic bitData,
	input wire logic alarmBitValid,
	input wire logic alarmBit,
	input wire logic fBitValid,
	input wire logic fBitError,
	input wire logic mBitValid,
	input wire logic mBitError,
	input wire logic syncFound,
	input wire logic fasValid,
	input wire logic fasOk,
	output logic ais,
	output logic lof,
	output logic rai
);
	function automatic logic [2:0] popCount(input logic [4:0] v);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < 5; i++) begin
			n = n + {2'h0, v[i]};
		end
		return n;
	endfunction

	logic [12:0] bitCnt_reg;
	logic [3:0] zeroCnt_reg;
	logic prevWin_reg;
	logic prevLow_reg;
	logic [2:0] raiCnt_reg;
	logic [TRAS_F_WINDOW-1:0] fHist_reg;
	logic [TRAS_M_WINDOW-1:0] mHist_reg;
	logic [2:0] fasBad_reg;

	wire isT2 = (mode == TRAS_MODE_T2);
	wire [12:0] winLen = isT2 ? TRAS_T2_WIN_BITS : (mode == TRAS_MODE_E2) ? TRAS_E2_FRAME_BITS : TRAS_G747_FRAME_BITS;
	wire winEnd = bitValid && (bitCnt_reg == winLen - 13'h0001);
	wire [3:0] zeroSat = (zeroCnt_reg == 4'hf) ? zeroCnt_reg : zeroCnt_reg + 4'h1;
	wire [3:0] zeroTotal = (bitValid && !bitData) ? zeroSat : zeroCnt_reg;
	wire winLow = zeroTotal <= (isT2 ? TRAS_T2_AIS_MAX_ZEROS : TRAS_FRM_AIS_MAX_ZEROS);
	wire raiActive = isT2 ? !alarmBit : alarmBit;
	wire [2:0] raiCntInc = raiCnt_reg + 3'h1;
	wire [TRAS_F_WINDOW-1:0] fHistNext = fBitValid ? {fHist_reg[TRAS_F_WINDOW-2:0], fBitError} : fHist_reg;
	wire [TRAS_M_WINDOW-1:0] mHistNext = mBitValid ? {mHist_reg[TRAS_M_WINDOW-2:0], mBitError} : mHist_reg;
	wire t2LofHit = (popCount(fHistNext) >= TRAS_ERR_LIMIT) || (popCount({1'b0, mHistNext}) >= TRAS_ERR_LIMIT);
	wire [2:0] fasBadInc = (fasBad_reg == TRAS_FAS_BAD_LIMIT) ? fasBad_reg : fasBad_reg + 3'h1;

	// AIS zero counting over fixed windows
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bitCnt_reg <= 13'h0000;
			zeroCnt_reg <= 4'h0;
			prevWin_reg <= 1'b0;
			prevLow_reg <= 1'b0;
			ais <= 1'b0;
		end else if (winEnd) begin
			bitCnt_reg <= 13'h0000;
			zeroCnt_reg <= 4'h0;
			prevWin_reg <= 1'b1;
			prevLow_reg <= winLow;
			if (isT2) begin
				ais <= winLow;
			end else if (prevWin_reg && prevLow_reg == winLow) begin
				ais <= winLow;
			end
		end else if (bitValid) begin
			bitCnt_reg <= (bitCnt_reg >= winLen) ? 13'h0000 : bitCnt_reg + 13'h0001;
			zeroCnt_reg <= zeroTotal;
		end
	end

	// Remote alarm needs four agreeing frames to change
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			raiCnt_reg <= 3'h0;
			rai <= 1'b0;
		end else if (alarmBitValid) begin
			if (raiActive == rai) begin
				raiCnt_reg <= 3'h0;
			end else if (raiCntInc == TRAS_RAI_FRAMES) begin
				raiCnt_reg <= 3'h0;
				rai <= raiActive;
			end else begin
				raiCnt_reg <= raiCntInc;
			end
		end
	end

	// Loss of frame
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fHist_reg <= '0;
			mHist_reg <= '0;
			fasBad_reg <= 3'h0;
			lof <= 1'b0;
		end else if (isT2) begin
			fasBad_reg <= 3'h0;
			if (syncFound) begin
				fHist_reg <= '0;
				mHist_reg <= '0;
				lof <= 1'b0;
			end else begin
				fHist_reg <= fHistNext;
				mHist_reg <= mHistNext;
				if (t2LofHit) begin
					lof <= 1'b1;
				end
			end
		end else if (fasValid) begin
			fHist_reg <= '0;
			mHist_reg <= '0;
			if (fasOk) begin
				fasBad_reg <= 3'h0;
				lof <= 1'b0;
			end else begin
				fasBad_reg <= fasBadInc;
				if (fasBadInc == TRAS_FAS_BAD_LIMIT) begin
					lof <= 1'b1;
				end
			end
		end
	end
endmodule // tras_detector

// ---- logic/tras_top.sv ----
`timescale 1ns/1ns
module tras_top import tras_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic [TRAS_TRIBS-1:0] bitValid,
	input wire logic [TRAS_TRIBS-1:0] bitData,
	input wire logic [TRAS_TRIBS-1:0] frameStart,
	input wire logic [TRAS_TRIBS-1:0] alarmBitValid,
	input wire logic [TRAS_TRIBS-1:0] alarmBit,
	input wire logic [TRAS_TRIBS-1:0] fBitValid,
	input wire logic [TRAS_TRIBS-1:0] fBitError,
	input wire logic [TRAS_TRIBS-1:0] mBitValid,
	input wire logic [TRAS_TRIBS-1:0] mBitError,
	input wire logic [TRAS_TRIBS-1:0] syncFound,
	input wire logic [TRAS_TRIBS-1:0] fasValid,
	input wire logic [TRAS_TRIBS-1:0] fasOk,
	input wire logic [TRAS_E2_TRIBS-1:0] e2NationalValid,
	input wire logic [TRAS_E2_TRIBS-1:0] e2NationalBit
);
	logic [TRAS_TRIBS-1:0] aisLive;
	logic [TRAS_TRIBS-1:0] lofLive;
	logic [TRAS_TRIBS-1:0] raiLive;
	logic [TRAS_TRIBS-1:0] raiPrev_reg;
	logic [TRAS_TRIBS-1:0] remoteAlarmLatched_reg;
	logic [TRAS_TRIBS-1:0] remoteAlarmLatched_next;
	logic remoteAlarmIrqEnable_reg;
	logic [TRAS_E2_TRIBS-1:0] e2NationalBitRx_reg;
	logic [TRAS_E2_TRIBS-1:0] e2NationalBitRx_next;
	logic [TRAS_E2_TRIBS-1:0] e2FrameStartEvent_reg;
	logic [TRAS_E2_TRIBS-1:0] e2FrameStartEvent_next;
	logic masterStatus_reg;
	logic masterStatus_next;
	logic masterStatusMask_reg;
	logic [1:0] config_reg;
	logic [31:0] readMux;
	tras_mode_t modeSel;

	// APB decode
	wire apbSetup = psel && !penable;
	wire apbDone = psel && penable && pready;
	wire hitStatus2 = (paddr == TRAS_OFS_STATUS2);
	wire hitMaster = (paddr == TRAS_OFS_MASTER);
	wire hitMask = (paddr == TRAS_OFS_MASK);
	wire hitLive = (paddr == TRAS_OFS_LIVE);
	wire hitConfig = (paddr == TRAS_OFS_CONFIG);
	wire hitAny = hitStatus2 || hitMaster || hitMask || hitLive || hitConfig;
	wire wrDone = apbDone && pwrite;
	wire rdStatus2 = apbDone && !pwrite && hitStatus2;
	wire rdMaster = apbDone && !pwrite && hitMaster;

	assign modeSel = (config_reg == 2'h1) ? TRAS_MODE_E2 : (config_reg == 2'h2) ? TRAS_MODE_G747 : TRAS_MODE_T2;
	wire isE2 = (modeSel == TRAS_MODE_E2);

	genvar t;
	generate
		for (t = 0; t < TRAS_TRIBS; t++) begin : gTrib
			tras_detector uDet (
				.clk(clk),
				.rst(rst),
				.mode(modeSel),
				.bitValid(bitValid[t]),
				.bitData(bitData[t]),
				.alarmBitValid(alarmBitValid[t]),
				.alarmBit(alarmBit[t]),
				.fBitValid(fBitValid[t]),
				.fBitError(fBitError[t]),
				.mBitValid(mBitValid[t]),
				.mBitError(mBitError[t]),
				.syncFound(syncFound[t]),
				.fasValid(fasValid[t]),
				.fasOk(fasOk[t]),
				.ais(aisLive[t]),
				.lof(lofLive[t]),
				.rai(raiLive[t])
			);
		end
	endgenerate

	// Read-clear only touches bits that the read returned, except that any STATUS2 read clears the master bit
	wire [TRAS_TRIBS-1:0] raiReported = prdata[TRAS_RAI_LSB +: TRAS_TRIBS];
	wire [TRAS_E2_TRIBS-1:0] sofReported = prdata[TRAS_SOF_LSB +: TRAS_E2_TRIBS];
	wire [TRAS_TRIBS-1:0] raiClear = rdStatus2 ? raiReported : '0;
	wire [TRAS_E2_TRIBS-1:0] sofClear = rdStatus2 ? sofReported : '0;
	wire [TRAS_E2_TRIBS-1:0] sofSet = isE2 ? frameStart[TRAS_E2_TRIBS-1:0] : '0;
	wire [TRAS_E2_TRIBS-1:0] snLoad = isE2 ? e2NationalValid : '0;
	wire raiChange = |(raiLive ^ raiPrev_reg);
	wire masterSet = raiChange && remoteAlarmIrqEnable_reg;
	wire masterClear = rdStatus2 || (rdMaster && prdata[TRAS_MSR_RAI_BIT]);

	assign remoteAlarmLatched_next = raiLive | (remoteAlarmLatched_reg & ~raiClear);
	assign e2FrameStartEvent_next = sofSet | (e2FrameStartEvent_reg & ~sofClear);
	assign e2NationalBitRx_next = (e2NationalBitRx_reg & ~snLoad) | (e2NationalBit & snLoad);
	assign masterStatus_next = masterSet || (masterStatus_reg && !masterClear);

	always_comb begin
		readMux = 32'h0000_0000;
		if (hitStatus2) begin
			readMux[TRAS_RAI_LSB +: TRAS_TRIBS] = remoteAlarmLatched_reg;
			readMux[TRAS_IE_BIT] = remoteAlarmIrqEnable_reg;
			readMux[TRAS_SN_LSB +: TRAS_E2_TRIBS] = e2NationalBitRx_reg;
			readMux[TRAS_SOF_LSB +: TRAS_E2_TRIBS] = e2FrameStartEvent_reg;
		end else if (hitMaster) begin
			readMux[TRAS_MSR_RAI_BIT] = masterStatus_reg;
		end else if (hitMask) begin
			readMux[TRAS_MSR_RAI_BIT] = masterStatusMask_reg;
		end else if (hitLive) begin
			readMux[TRAS_LIVE_AIS_LSB +: TRAS_TRIBS] = aisLive;
			readMux[TRAS_LIVE_LOF_LSB +: TRAS_TRIBS] = lofLive;
			readMux[TRAS_LIVE_RAI_LSB +: TRAS_TRIBS] = raiLive;
		end else if (hitConfig) begin
			readMux[1:0] = config_reg;
		end
	end

	// Bus slave: answer one cycle after setup
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= apbSetup;
			pslverr <= apbSetup && !hitAny;
			if (apbSetup) begin
				prdata <= pwrite ? 32'h0000_0000 : readMux;
			end
		end
	end

	// Software-written registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			remoteAlarmIrqEnable_reg <= TRAS_IE_RST;
			masterStatusMask_reg <= TRAS_MASK_RST;
			config_reg <= TRAS_CONFIG_RST;
		end else if (wrDone) begin
			if (hitStatus2) begin
				remoteAlarmIrqEnable_reg <= pwdata[TRAS_IE_BIT];
			end else if (hitMask) begin
				masterStatusMask_reg <= pwdata[TRAS_MSR_RAI_BIT];
			end else if (hitConfig) begin
				config_reg <= pwdata[1:0];
			end
		end
	end

	// Status latches and interrupt
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			raiPrev_reg <= '0;
			remoteAlarmLatched_reg <= '0;
			e2FrameStartEvent_reg <= '0;
			e2NationalBitRx_reg <= '0;
			masterStatus_reg <= 1'b0;
			irq <= 1'b0;
		end else begin
			raiPrev_reg <= raiLive;
			remoteAlarmLatched_reg <= remoteAlarmLatched_next;
			e2FrameStartEvent_reg <= e2FrameStartEvent_next;
			e2NationalBitRx_reg <= e2NationalBitRx_next;
			masterStatus_reg <= masterStatus_next;
			irq <= masterStatus_reg && masterStatusMask_reg;
		end
	end
endmodule // tras_top

// ---- verification/test_tributary_rx_alarm_status.sv ----
`timescale 1ns/1ns
module test_tributary_rx_alarm_status import tras_pkg::*; ;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdata;
	logic pready, pslverr, irq, rerr;
	logic [TRAS_TRIBS-1:0] bitValid, bitData, frameStart, alarmBitValid, alarmBit, fBitValid, fBitError;
	logic [TRAS_TRIBS-1:0] mBitValid, mBitError, syncFound, fasValid, fasOk;
	logic [TRAS_E2_TRIBS-1:0] e2NationalValid, e2NationalBit;
	int err_count = 0, num_checks = 0, n;
	tras_top tras_top_inst (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.irq, .bitValid, .bitData, .frameStart, .alarmBitValid, .alarmBit, .fBitValid, .fBitError, .mBitValid,
		.mBitError, .syncFound, .fasValid, .fasOk, .e2NationalValid, .e2NationalBit);
	tras_far_end tras_far_end_inst (.clk, .bitValid, .bitData, .frameStart, .alarmBitValid, .alarmBit,
		.fBitValid, .fBitError, .mBitValid, .mBitError, .syncFound, .fasValid, .fasOk, .e2NationalValid,
		.e2NationalBit);
	initial forever #2 clk = ~clk;
	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		results();
	end
	task results;
		if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdb(input logic [7:0] a, input int b, input logic e);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h bit %0d", a, b), {31'h0, e}, {31'h0, rdata[b]});
	endtask
	task pls(input int k, input int t, input logic v, input int c);
		repeat (c) tras_far_end_inst.pulse(k, t, v);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rdb(TRAS_OFS_STATUS2, TRAS_IE_BIT, 1'b0);
		rdb(TRAS_OFS_MASK, 0, 1'b0);
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, rerr});
		apb(1'b1, TRAS_OFS_STATUS2, 32'h80);
		apb(1'b1, TRAS_OFS_MASK, 32'h1);
		rdb(TRAS_OFS_STATUS2, TRAS_IE_BIT, 1'b1);
		for (int m = 0; m < 3; m++) begin
			apb(1'b1, TRAS_OFS_CONFIG, 32'(m));
			pls(0, m, m != 0, 3);
			rdb(TRAS_OFS_LIVE, TRAS_LIVE_RAI_LSB + m, 1'b0);
			pls(0, m, m != 0, 1);
			rdb(TRAS_OFS_LIVE, TRAS_LIVE_RAI_LSB + m, 1'b1);
			chk("irq set", 32'h1, {31'h0, irq});
			rdb(TRAS_OFS_STATUS2, m, 1'b1);
			rdb(TRAS_OFS_STATUS2, m, 1'b1);
			pls(0, m, m == 0, 4);
			rdb(TRAS_OFS_LIVE, TRAS_LIVE_RAI_LSB + m, 1'b0);
			rdb(TRAS_OFS_STATUS2, m, 1'b1);
			rdb(TRAS_OFS_STATUS2, m, 1'b0);
			rdb(TRAS_OFS_MASTER, TRAS_MSR_RAI_BIT, 1'b0);
			chk("irq clear", 32'h0, {31'h0, irq});
		end
		apb(1'b1, TRAS_OFS_MASK, 32'h0);
		pls(0, 3, 1'b1, 4);
		// Give the summary bit time to reach irq if the mask failed
		repeat (3) @(posedge clk);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, TRAS_OFS_MASK, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq unmasked", 32'h1, {31'h0, irq});
		apb(1'b1, TRAS_OFS_MASK, 32'h0);
		repeat (2) @(posedge clk);
		chk("irq remasked", 32'h0, {31'h0, irq});
		apb(1'b1, TRAS_OFS_MASK, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq unmasked again", 32'h1, {31'h0, irq});
		apb(1'b1, TRAS_OFS_STATUS2, 32'h0);
		rdb(TRAS_OFS_MASTER, TRAS_MSR_RAI_BIT, 1'b1);
		pls(0, 3, 1'b0, 4);
		rdb(TRAS_OFS_MASTER, TRAS_MSR_RAI_BIT, 1'b0);
		// Four-tributary mode: only tributaries 0 to 2 are exercised
		apb(1'b1, TRAS_OFS_CONFIG, 32'h1);
		pls(5, 2, 1'b1, 1);
		rdb(TRAS_OFS_STATUS2, TRAS_SOF_LSB + 2, 1'b1);
		rdb(TRAS_OFS_STATUS2, TRAS_SOF_LSB + 2, 1'b0);
		pls(6, 1, 1'b1, 1);
		rdb(TRAS_OFS_STATUS2, TRAS_SN_LSB + 1, 1'b1);
		pls(6, 1, 1'b0, 1);
		rdb(TRAS_OFS_STATUS2, TRAS_SN_LSB + 1, 1'b0);
		pls(4, 0, 1'b0, 3);
		rdb(TRAS_OFS_LIVE, TRAS_LIVE_LOF_LSB, 1'b0);
		pls(4, 0, 1'b0, 1);
		rdb(TRAS_OFS_LIVE, TRAS_LIVE_LOF_LSB, 1'b1);
		pls(4, 0, 1'b1, 1);
		rdb(TRAS_OFS_LIVE, TRAS_LIVE_LOF_LSB, 1'b0);
		// Mode code 3 also selects T2 framing
		apb(1'b1, TRAS_OFS_CONFIG, 32'h3);
		rdb(TRAS_OFS_CONFIG, 1, 1'b1);
		pls(1, 1, 1'b1, 1);
		rdb(TRAS_OFS_LIVE, TRAS_LIVE_LOF_LSB + 1, 1'b0);
		pls(1, 1, 1'b1, 1);
		rdb(TRAS_OFS_LIVE, TRAS_LIVE_LOF_LSB + 1, 1'b1);
		pls(1, 1, 1'b0, 5);
		pls(3, 1, 1'b1, 1);
		rdb(TRAS_OFS_LIVE, TRAS_LIVE_LOF_LSB + 1, 1'b0);
		pls(2, 2, 1'b1, 2);
		rdb(TRAS_OFS_LIVE, TRAS_LIVE_LOF_LSB + 2, 1'b1);
		for (int m = 0; m < 3; m++) begin
			apb(1'b1, TRAS_OFS_CONFIG, 32'(m));
			n = (m == 0) ? 2 * int'(TRAS_T2_WIN_BITS) : 3 * int'(m == 1 ? TRAS_E2_FRAME_BITS : TRAS_G747_FRAME_BITS);
			tras_far_end_inst.stream(4 + m, n + 8, 1'b1);
			rdb(TRAS_OFS_LIVE, TRAS_LIVE_AIS_LSB + 4 + m, 1'b1);
			tras_far_end_inst.stream(4 + m, n + 8, 1'b0);
			rdb(TRAS_OFS_LIVE, TRAS_LIVE_AIS_LSB + 4 + m, 1'b0);
		end
		results();
	end
endmodule // test_tributary_rx_alarm_status
bind tras_top tras_monitor tras_monitor_inst (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .irq);

// ---- verification/tras_far_end.sv ----
`timescale 1ns/1ns
module tras_far_end import tras_pkg::*; (
	input wire logic clk,
	output logic [TRAS_TRIBS-1:0] bitValid,
	output logic [TRAS_TRIBS-1:0] bitData,
	output logic [TRAS_TRIBS-1:0] frameStart,
	output logic [TRAS_TRIBS-1:0] alarmBitValid,
	output logic [TRAS_TRIBS-1:0] alarmBit,
	output logic [TRAS_TRIBS-1:0] fBitValid,
	output logic [TRAS_TRIBS-1:0] fBitError,
	output logic [TRAS_TRIBS-1:0] mBitValid,
	output logic [TRAS_TRIBS-1:0] mBitError,
	output logic [TRAS_TRIBS-1:0] syncFound,
	output logic [TRAS_TRIBS-1:0] fasValid,
	output logic [TRAS_TRIBS-1:0] fasOk,
	output logic [TRAS_E2_TRIBS-1:0] e2NationalValid,
	output logic [TRAS_E2_TRIBS-1:0] e2NationalBit
);
	initial begin
		{bitValid, bitData, frameStart, alarmBitValid, alarmBit, fBitValid, fBitError} = '0;
		{mBitValid, mBitError, syncFound, fasValid, fasOk, e2NationalValid, e2NationalBit} = '0;
	end
	task pulse(input int k, input int t, input logic v);
		@(posedge clk);
		alarmBit[t] <= v;
		fBitError[t] <= v;
		mBitError[t] <= v;
		fasOk[t] <= v;
		e2NationalBit[t % TRAS_E2_TRIBS] <= v;
		case (k)
			0: alarmBitValid[t] <= 1'b1;
			1: fBitValid[t] <= 1'b1;
			2: mBitValid[t] <= 1'b1;
			3: syncFound[t] <= 1'b1;
			4: fasValid[t] <= 1'b1;
			5: frameStart[t] <= 1'b1;
			default: e2NationalValid[t % TRAS_E2_TRIBS] <= 1'b1;
		endcase
		@(posedge clk);
		{alarmBitValid, fBitValid, mBitValid, syncFound, fasValid, frameStart, e2NationalValid} <= '0;
		// Alarm, F, M and FAS value lines toggle so stale values never look valid; e2NationalBit is left as driven
		{alarmBit, fBitError, mBitError, fasOk} <= ~{alarmBit, fBitError, mBitError, fasOk};
	endtask
	task stream(input int t, input int n, input logic v);
		@(posedge clk);
		bitValid[t] <= 1'b1;
		bitData[t] <= v;
		repeat (n) @(posedge clk);
		bitValid[t] <= 1'b0;
		bitData[t] <= ~v;
	endtask
endmodule // tras_far_end

// ---- verification/tras_monitor.sv ----
`timescale 1ns/1ns
module tras_monitor import tras_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence setupS;
		psel && !penable;
	endsequence
	sequence accS;
		psel && penable && pready;
	endsequence
	sequence rdS;
		accS ##0 !pwrite;
	endsequence
	setup_ready_a: assert property (setupS |=> pready) else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
	ready_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
	error_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
	unmapped_zero_a: assert property (rdS ##0 pslverr |-> prdata == 32'h0) else $error("unmapped data");
	mask_irq_a: assert property (accS ##0 (pwrite && paddr == TRAS_OFS_MASK && !pwdata[0]) |-> ##2 !irq)
		else $error("irq with mask clear");
	live_spare_a: assert property (rdS ##0 paddr == TRAS_OFS_LIVE |-> prdata[31:23] == 9'h0 && !prdata[15])
		else $error("live spare bits");
	status_spare_a: assert property (rdS ##0 paddr == TRAS_OFS_STATUS2 |-> prdata[31:16] == 16'h0)
		else $error("status spare bits");
endmodule // tras_monitor
